// ### lcd_core.sv
// Purpose: three-wire serial load, latch classification and second-order modulator
// Assumes: serial pins are asynchronous and sampled by sys_clk; serial clock <= 10 MHz
// Notes:   latched words pass a fifo before reaching the dac latch
// Function
// - data shifted in msb first on clock rise
// - latch rise pushes shift register word into the fifo
// - count clock pulses between latch strobes
// - exactly sixteen edges gives 16-bit normal transfer
// - normal code maps 4 to 20 mA
// - 17 to 31 pulses, counted modulo 32, gives alarm data
// - longer writes keep last seventeen bits
// - alarm 17-bit transfer maps 0 to 32 mA
// - reference overload forces reset, clears latch
// - second-order modulator makes single-bit stream
// - edge count classified modulo 32
// - serial clock up to 10 MHz
`timescale 1ns/1ps
module lcd_core
	import lcd_pkg::*;
#(
	parameter int unsigned DEPTH = lcd_pkg::FIFO_DEPTH
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        ser_clock,
	input  wire logic        ser_data,
	input  wire logic        ser_latch,
	input  wire logic        ref_overload,
	output logic             dac_bit,
	output logic             dac_enable,
	output logic             osc_running,
	output logic             alarm_mode,
	output logic [16:0]      dac_code,
	output logic             word_dropped
);
	import lcd_pkg::*;

	// input synchronisers, stage one read only by stage two
	logic [2:0] sync1_r;          // first stage: clock, data, latch
	logic [2:0] sync2_r;          // second stage
	logic       clk_prev_r;       // previous synced serial clock
	logic       lat_prev_r;       // previous synced latch
	logic       ovl1_r;           // overload first stage
	logic       ovl2_r;           // overload second stage
	logic       por;              // internal power-on reset
	logic       clk_rise;         // serial clock rising edge
	logic       lat_rise;         // latch rising edge
	logic [16:0] shift_r;         // input shift register
	logic [CNT_BITS-1:0] cnt_r;   // edge count, wraps modulo 32
	lcd_word_s  word;             // word handed to fifo
	lcd_word_s  fifo_out;         // word leaving fifo
	logic       f_in_ready;       // fifo can accept
	logic       f_out_valid;      // fifo has a word
	logic       tick;             // modulator update enable
	logic [$clog2(OSC_DIV)-1:0] div_r; // oscillator divider
	logic [16:0] latch_r;         // dac latch code
	logic       alarm_r;          // mode of latched code
	logic signed [20:0] int1_r;   // first integrator
	logic signed [20:0] int2_r;   // second integrator
	logic signed [20:0] fb;       // feedback level
	logic signed [20:0] in_val;   // modulator input
	logic signed [20:0] int1_nxt; // first integrator next
	logic signed [20:0] int2_nxt; // second integrator next

	// two-flop sampling of the asynchronous pins
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_r <= 3'h1; // idle levels: clock low, data low, latch high
			sync2_r <= 3'h1; // matches the latch idle level, so no false rise
			ovl1_r  <= 1'b0;
			ovl2_r  <= 1'b0;
		end else begin
			sync1_r <= {ser_clock, ser_data, ser_latch};
			sync2_r <= sync1_r;
			ovl1_r  <= ref_overload;
			ovl2_r  <= ovl1_r;
		end
	end

	assign por = srst | ovl2_r; // overload acts as power-on reset

	// edge history; bit rate up to 10 MHz leaves >= 12 samples per bit
	always_ff @(posedge sys_clk) begin
		if (por) begin
			clk_prev_r <= 1'b0;
			lat_prev_r <= 1'b1; // latch idles high; avoids a phantom latch after reset
		end else begin
			clk_prev_r <= sync2_r[2];
			lat_prev_r <= sync2_r[0];
		end
	end

	assign clk_rise = sync2_r[2] & ~clk_prev_r;
	assign lat_rise = sync2_r[0] & ~lat_prev_r;

	// shift register keeps last 17 bits, msb first
	always_ff @(posedge sys_clk) begin
		if (por) begin
			shift_r <= CODE_RST;
		end else if (clk_rise) begin
			shift_r <= {shift_r[15:0], sync2_r[1]};
		end
	end

	// edge counter restarts at each latch, wraps modulo 32
	always_ff @(posedge sys_clk) begin
		if (por) begin
			cnt_r <= '0;
		end else if (lat_rise) begin
			cnt_r <= '0;
		end else if (clk_rise) begin
			cnt_r <= cnt_r + 1'b1; // natural 5-bit wrap
		end
	end

	// classify at the latch edge: 0..16 normal, 17..31 alarm
	always_comb begin
		word.alarm = (cnt_r > NORM_MAX_CNT);
		if (word.alarm) begin
			word.code = shift_r; // 17-bit transfer
		end else begin
			word.code = {1'b0, shift_r[15:0]}; // 16-bit transfer
		end
	end

	// word lost only if fifo full when latch arrives
	always_ff @(posedge sys_clk) begin
		if (por) begin
			word_dropped <= 1'b0;
		end else begin
			word_dropped <= lat_rise & ~f_in_ready;
		end
	end

	lcd_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (por),
		.in_valid  (lat_rise),
		.in_ready  (f_in_ready),
		.in_data   (word),
		.out_valid (f_out_valid),
		.out_ready (tick),
		.out_data  (fifo_out)
	);

	// internal oscillator divider, stopped during power-on reset
	always_ff @(posedge sys_clk) begin
		if (por) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	assign tick = (div_r == '1);

	// dac latch, cleared on reset, loaded from fifo on modulator tick
	always_ff @(posedge sys_clk) begin
		if (por) begin
			latch_r <= CODE_RST;
			alarm_r <= 1'b0;
		end else if (tick && f_out_valid) begin
			latch_r <= fifo_out.code;
			alarm_r <= fifo_out.alarm;
		end
	end

	// modulator input on a common 17-bit current scale: 1 lsb = 32/131072 mA
	// normal: 4 mA offset (0x04000) plus the 16-bit code; both modes share one
	// lsb size, so the normal code maps 4..20 mA with no scaling
	// alarm: code maps 0..32 mA directly
	always_comb begin
		if (alarm_r) begin
			in_val = 21'(latch_r);
		end else begin
			in_val = 21'(17'h04000) + 21'(latch_r[15:0]);
		end
		fb       = dac_bit ? 21'sh20000 : 21'sh00000;
		int1_nxt = int1_r + in_val - fb;
		int2_nxt = int2_r + int1_nxt - fb;
	end

	// second-order single-bit modulator
	always_ff @(posedge sys_clk) begin
		if (por) begin
			int1_r  <= '0;
			int2_r  <= '0;
			dac_bit <= 1'b0;
		end else if (tick) begin
			int1_r  <= int1_nxt;
			int2_r  <= int2_nxt;
			dac_bit <= (int2_nxt >= 21'sh10000);
		end
	end

	// status outputs
	always_ff @(posedge sys_clk) begin
		if (por) begin
			dac_enable  <= 1'b0;
			osc_running <= 1'b0;
		end else begin
			dac_enable  <= 1'b1;
			osc_running <= 1'b1;
		end
	end

	assign alarm_mode = alarm_r;
	assign dac_code   = latch_r;
endmodule

// ### lcd_core_chk.sv
// Purpose: assertions on the lcd_core ports
// Assumes: one sys_clk domain, srst sync high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module lcd_core_chk
	import lcd_pkg::*;
#(
	parameter int unsigned DEPTH = 16
) (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        ser_latch,
	input wire logic        ref_overload,
	input wire logic        dac_bit,
	input wire logic        dac_enable,
	input wire logic        osc_running,
	input wire logic        alarm_mode,
	input wire logic [16:0] dac_code
);
	logic       lat_q_r; // latch pin one cycle back
	logic [3:0] age_r;   // cycles since a latch rise, saturating
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// age of the last latch rise, so updates can be tied to it
	always_ff @(posedge sys_clk) begin
		lat_q_r <= ser_latch;
		if (srst)
			age_r <= 4'hF;
		else if (ser_latch && !lat_q_r)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	end
	AST_RST_CLR: assert property (disable iff (1'b0) srst |=> dac_code == 17'h00000
		&& !alarm_mode && !dac_enable && !osc_running && !dac_bit) else $error("reset clear");
	AST_OVL_CLR: assert property (ref_overload [*4] |=> dac_code == 17'h00000
		&& !dac_enable && !osc_running) else $error("overload clear");
	AST_NRM_TOP: assert property (!alarm_mode |-> !dac_code[16]) else $error("normal top");
	AST_OFF_BIT: assert property (!dac_enable |-> !dac_bit) else $error("bit when off");
	AST_OSC_RUN: assert property (!osc_running |-> dac_code == 17'h00000
		&& !alarm_mode && !dac_bit) else $error("latch not clear while osc stopped");
	AST_BIT_RATE: assert property ($changed(dac_bit) |=>
		($stable(dac_bit) || !dac_enable) [*3]) else $error("bit rate");
	AST_STANDS: assert property ($changed(dac_code) && dac_enable && $past(dac_enable)
		|-> age_r <= 4'hA) else $error("code moved");
	AST_MODE_STEP: assert property ($changed(alarm_mode) && dac_enable && $past(dac_enable)
		|-> age_r <= 4'hA) else $error("mode moved");
endmodule

// ### lcd_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; pop and push may share a cycle
`timescale 1ns/1ps
module lcd_fifo #(
	parameter int unsigned WIDTH = 18,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // storage array
	logic [AW-1:0]    wr_ptr_r;     // write index
	logic [AW-1:0]    rd_ptr_r;     // read index
	logic [AW:0]      count_r;      // words held
	logic             push;         // accepted write
	logic             pop;          // accepted read

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_r];

	// storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### lcd_host.sv
// Purpose: host serial port model for clock, data and latch
// Assumes: 64 ns serial clock, clock idle low between frames
// Notes:   released data shows the inverse of the last bit
`timescale 1ns/1ps
module lcd_host (
	input  wire logic sys_clk,
	output logic      ser_clock,
	output logic      ser_data,
	output logic      ser_latch
);
	// idle pins: clock low, latch high
	initial begin
		ser_clock = 1'b0;
		ser_data = 1'b0;
		ser_latch = 1'b1;
	end
	// one write of k bits, msb first, then the latch rise
	task automatic load(logic [63:0] v, int k);
		int b;
		@(posedge sys_clk) #1 ser_latch = 1'b0;
		ser_data = v[k-1]; // msb out first
		for (b = k - 1; b >= 0; b--) begin
			repeat (4) @(posedge sys_clk);
			#1 ser_clock = 1'b1; // 4 cycles low, 4 high
			repeat (4) @(posedge sys_clk);
			#1 ser_clock = 1'b0;
			ser_data = (b > 0) ? v[b-1] : ~v[0]; // next bit, or released
		end
		repeat (4) @(posedge sys_clk);
		#1 ser_latch = 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask
endmodule

// ### lcd_pkg.sv
// Purpose: shared constants and carrier types for the loop current dac serial load block
// Assumes: one system clock at 125 MHz, serial pins sampled by that clock
// Notes:   all numbers used by more than one file live here
package lcd_pkg;
	localparam int unsigned SYS_CLK_HZ      = 125_000_000; // system clock rate
	localparam int unsigned SER_MAX_HZ      = 10_000_000;  // fastest serial clock accepted
	localparam int unsigned SER_MIN_PER_CYC = SYS_CLK_HZ / SER_MAX_HZ; // cycles per bit, floor
	localparam int unsigned NORM_BITS       = 16;          // normal-range word width
	localparam int unsigned ALARM_BITS      = 17;          // alarm word width
	localparam int unsigned CNT_BITS        = 5;           // edge counter, wraps modulo 32
	localparam logic [4:0]  NORM_MAX_CNT    = 5'h10;       // counts 0..16 select normal mode
	localparam int unsigned FIFO_DEPTH      = 16;          // words buffered between latch and dac
	localparam int unsigned OSC_DIV         = 4;           // modulator update divider
	localparam logic [16:0] CODE_RST        = 17'h00000;   // latch value after reset

	// one latched word: alarm flag plus 17-bit code
	typedef struct packed {
		logic        alarm;
		logic [16:0] code;
	} lcd_word_s;
	localparam int unsigned WORD_W = 18; // width of lcd_word_s
endpackage

// ### tb_lcd_core.sv
// Purpose: self-checking bench for lcd_core
// Assumes: host model drives the serial pins
// Notes:   random words mixed with edge-count corners
`timescale 1ns/1ps
module tb_lcd_core;
	import lcd_pkg::*;
	logic        sys_clk, srst, ref_overload, ser_clock, ser_data, ser_latch;
	logic        dac_bit, dac_enable, osc_running, alarm_mode, word_dropped;
	logic [16:0] dac_code; // latched code seen
	logic [63:0] w;        // word sent
	logic        dropped = 1'b0; // any refused latch seen
	int          miscompares = 0, n_tests = 0, seed = 32'h5d4cc4fd, i, n, ones;
	int          lens[6] = '{16, 17, 24, 16, 33, 32}; // edge counts tried
	lcd_core #(.DEPTH(16)) dut (.sys_clk, .srst, .ser_clock, .ser_data, .ser_latch,
		.ref_overload, .dac_bit, .dac_enable, .osc_running, .alarm_mode, .dac_code,
		.word_dropped);
	lcd_host host (.sys_clk, .ser_clock, .ser_data, .ser_latch);
	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// sticky record of any latch the design refused
	always @(posedge sys_clk) begin
		if (word_dropped === 1'b1)
			dropped <= 1'b1;
	end
	// expected {alarm, code} from word and edge count
	function automatic logic [17:0] expect_word(logic [63:0] v, int k);
		if (k % 32 > 16)
			return {1'b1, v[16:0]};
		return {2'b00, v[15:0]};
	endfunction
	task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ones on the bitstream over 2048 cycles
	task automatic density(logic [63:0] v, int k, int exp);
		host.load(v, k);
		ones = 0;
		repeat (2048) @(posedge sys_clk) ones += dac_bit;
		check("density", {17'h0, ones > exp - 40 && ones < exp + 40}, 18'h1);
	endtask
	// main sequence
	initial begin
		srst = 1'b1;
		ref_overload = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 srst = 1'b0;
		check("reset", {alarm_mode, dac_code}, 18'h0);
		for (i = 0; i < 12; i++) begin
			n = lens[i % 6];
			w = {$random(seed), $random(seed)};
			if (n % 32 > 16)
				w[16:15] = 2'b01; // alarm codes kept in the usable span
			host.load(w, n);
			check("word", {alarm_mode, dac_code}, expect_word(w, n));
		end
		$display("word loads done");
		density(64'h8000, 16, 768);
		density(64'h10000, 17, 1024);
		$display("density done");
		#1 ref_overload = 1'b1;
		repeat (8) @(posedge sys_clk);
		check("overload", {dac_enable | osc_running | alarm_mode, dac_code}, 18'h0);
		#1 ref_overload = 1'b0;
		host.load(64'h1234, 16);
		check("after overload", {alarm_mode, dac_code}, 18'h01234);
		check("dropped", {17'h0, dropped}, 18'h0);
		$display("overload done");
		end_sim;
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		end_sim;
	end
endmodule
bind lcd_core lcd_core_chk #(.DEPTH(DEPTH)) chk (.sys_clk, .srst, .ser_latch, .ref_overload,
	.dac_bit, .dac_enable, .osc_running, .alarm_mode, .dac_code);
